/* File: rtl/dcsm_defs.vh */
`ifndef DCSM_DEFS_VH
`define DCSM_DEFS_VH

// transfer mode codes held in each control structure
`define DCSM_MODE_STOP 3'h0
`define DCSM_MODE_BASIC 3'h1
`define DCSM_MODE_AUTO 3'h2
`define DCSM_MODE_ALTERNATING_BUFFER_CODE 3'h3
`define DCSM_MODE_MEM_TASK_LIST_CODE 3'h4
`define DCSM_MODE_PERIPH_TASK_LIST_CODE 3'h6

// item size codes
`define DCSM_SIZE_8 2'h0
`define DCSM_SIZE_16 2'h1
`define DCSM_SIZE_32 2'h2

// structure select bit, placed above the channel number
`define DCSM_PRIMARY_STRUCT_SEL 1'b0
`define DCSM_ALTERNATE_STRUCT_SEL 1'b1

// reset values
`define DCSM_RST_EN 1'b0
`define DCSM_RST_ALT 1'b0
`define DCSM_RST_SEC_SEL 1'b0
`define DCSM_RST_PTL_FLAG 1'b0

`endif

/* File: rtl/dcsm_pick.v */
`timescale 1ns/1ps
`default_nettype none

// lowest eligible channel wins; fixed priority keeps service order simple
module dcsm_pick #(
	parameter N = 32,
	parameter W = 5
) (
	input wire [N-1:0] i_req,
	output reg o_any,
	output reg [W-1:0] o_idx
);

	integer i;

	always @* begin
		o_any = 1'b0;
		o_idx = {W{1'b0}};
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (i_req[i]) begin
				o_any = 1'b1;
				o_idx = i[W-1:0];
			end
		end
	end

endmodule

`default_nettype wire

/* File: rtl/dcsm_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "dcsm_defs.vh"

module dcsm_top #(
	parameter CHW = 5,
	parameter CW = 10,
	parameter [CHW-1:0] SW_CHAN = 30
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_en_set_stb,
	input wire i_dis_set_stb,
	input wire [CHW-1:0] i_en_chan,
	input wire [CHW:0] i_query_index,
	input wire i_xfer_set_stb,
	input wire [CHW:0] i_xfer_index,
	input wire [2:0] i_xfer_mode,
	input wire [1:0] i_xfer_size,
	input wire [CW-1:0] i_xfer_items,
	input wire i_sg_set_stb,
	input wire [CHW-1:0] i_sg_chan,
	input wire [CW-1:0] i_sg_task_total,
	input wire i_sg_periph_flag,
	input wire i_sw_req_stb,
	input wire [CHW-1:0] i_sw_req_chan,
	input wire i_sel_default_stb,
	input wire i_sel_secondary_stb,
	input wire [(1<<CHW)-1:0] i_sel_mask,
	input wire [(1<<CHW)-1:0] i_default_source_req,
	input wire [(1<<CHW)-1:0] i_secondary_source_req,
	output reg o_query_enabled,
	output reg [2:0] o_query_mode,
	output reg [CW-1:0] o_query_items,
	output reg [(1<<CHW)-1:0] o_enabled,
	output reg [(1<<CHW)-1:0] o_secondary_source_sel,
	output reg [(1<<CHW)-1:0] o_periph_task_list_flag,
	output reg [(1<<CHW)-1:0] o_periph_done,
	output reg o_sw_done_irq,
	output reg o_item_stb,
	output reg [CHW-1:0] o_item_chan,
	output reg [1:0] o_item_size
);

	localparam NCH = 1 << CHW;
	localparam NS = 2 * NCH;

	reg [1:0] rst_sync_r;
	wire rst_n;

	reg [NCH-1:0] en_r;
	reg [NCH-1:0] alt_r;
	reg [NCH-1:0] run_r;
	reg [NCH-1:0] sec_sel_r;
	reg [NCH-1:0] ptl_flag_r;
	reg [NCH-1:0] def_s1_r;
	reg [NCH-1:0] def_s2_r;
	reg [NCH-1:0] sec_s1_r;
	reg [NCH-1:0] sec_s2_r;
	reg [2:0] mode_r [0:NS-1];
	reg [1:0] size_r [0:NS-1];
	reg [CW-1:0] cnt_r [0:NS-1];

	wire [NCH-1:0] hw_req;
	wire [NCH-1:0] latching;
	wire [NCH-1:0] elig;
	wire any_elig;
	wire [CHW-1:0] sel_chan;
	wire [CHW:0] sel_s;
	wire [CHW:0] other_s;
	wire sel_last;
	wire sel_continue;
	wire [NCH-1:0] idle;
	reg [2:0] mode_ok;

	integer i;
	genvar c;

	// reset released through two flops so every flop sees a clean edge
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// peripheral request pins come from other logic; two-flop sync
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			def_s1_r <= {NCH{1'b0}};
			def_s2_r <= {NCH{1'b0}};
			sec_s1_r <= {NCH{1'b0}};
			sec_s2_r <= {NCH{1'b0}};
		end else begin
			def_s1_r <= i_default_source_req;
			def_s2_r <= def_s1_r;
			sec_s1_r <= i_secondary_source_req;
			sec_s2_r <= sec_s1_r;
		end
	end

	generate
		for (c = 0; c < NCH; c = c + 1) begin : g_chan
			localparam [CHW-1:0] CI = c;
			wire [2:0] cur_mode;
			assign cur_mode = mode_r[{alt_r[c], CI}];
			assign idle[c] = (cur_mode == `DCSM_MODE_STOP);
			// the unselected source is dropped entirely
			assign hw_req[c] = sec_sel_r[c] ? sec_s2_r[c] : def_s2_r[c];
			// auto-like modes keep running after the request drops
			assign latching[c] = (cur_mode == `DCSM_MODE_AUTO) ||
				(cur_mode == `DCSM_MODE_MEM_TASK_LIST_CODE);
			assign elig[c] = en_r[c] && (cur_mode != `DCSM_MODE_STOP) &&
				(hw_req[c] || run_r[c]);
		end
	endgenerate

	dcsm_pick #(
		.N(NCH),
		.W(CHW)
	) u_pick (
		.i_req(elig),
		.o_any(any_elig),
		.o_idx(sel_chan)
	);

	assign sel_s = {alt_r[sel_chan], sel_chan};
	assign other_s = {~alt_r[sel_chan], sel_chan};
	assign sel_last = (cnt_r[sel_s] <= {{(CW-1){1'b0}}, 1'b1});
	// switch buffers only if software has refilled the other structure
	assign sel_continue =
		(mode_r[sel_s] == `DCSM_MODE_ALTERNATING_BUFFER_CODE) &&
		(mode_r[other_s] != `DCSM_MODE_STOP);

	// only the six defined codes are stored; others read back as stopped
	always @* begin
		case (i_xfer_mode)
			`DCSM_MODE_BASIC: mode_ok = `DCSM_MODE_BASIC;
			`DCSM_MODE_AUTO: mode_ok = `DCSM_MODE_AUTO;
			`DCSM_MODE_ALTERNATING_BUFFER_CODE:
				mode_ok = `DCSM_MODE_ALTERNATING_BUFFER_CODE;
			`DCSM_MODE_MEM_TASK_LIST_CODE:
				mode_ok = `DCSM_MODE_MEM_TASK_LIST_CODE;
			`DCSM_MODE_PERIPH_TASK_LIST_CODE:
				mode_ok = `DCSM_MODE_PERIPH_TASK_LIST_CODE;
			default: mode_ok = `DCSM_MODE_STOP;
		endcase
	end

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_r <= {NCH{`DCSM_RST_EN}};
			alt_r <= {NCH{`DCSM_RST_ALT}};
			run_r <= {NCH{1'b0}};
			for (i = 0; i < NS; i = i + 1) begin
				mode_r[i] <= `DCSM_MODE_STOP;
				size_r[i] <= `DCSM_SIZE_8;
				cnt_r[i] <= {CW{1'b0}};
			end
		end else begin
			// hardware start latches the run for auto-like modes
			for (i = 0; i < NCH; i = i + 1) begin
				// stale latch would restart a refilled basic structure
				if (!en_r[i] || idle[i]) begin
					run_r[i] <= 1'b0;
				end else if (hw_req[i] && latching[i]) begin
					run_r[i] <= 1'b1;
				end
			end

			// one item per cycle for the winning channel
			if (any_elig) begin
				if (sel_last) begin
					cnt_r[sel_s] <= {CW{1'b0}};
					mode_r[sel_s] <= `DCSM_MODE_STOP;
					if (sel_continue) begin
						alt_r[sel_chan] <= ~alt_r[sel_chan];
					end else begin
						en_r[sel_chan] <= 1'b0;
						run_r[sel_chan] <= 1'b0;
					end
				end else begin
					cnt_r[sel_s] <= cnt_r[sel_s] - 1'b1;
				end
			end

			// software writes come last so they win a same-cycle clash
			if (i_xfer_set_stb) begin
				mode_r[i_xfer_index] <= mode_ok;
				size_r[i_xfer_index] <= i_xfer_size;
				cnt_r[i_xfer_index] <= i_xfer_items;
			end
			// task list runs from the primary structure; count is tasks
			if (i_sg_set_stb) begin
				mode_r[{`DCSM_PRIMARY_STRUCT_SEL, i_sg_chan}] <=
					i_sg_periph_flag ?
					`DCSM_MODE_PERIPH_TASK_LIST_CODE :
					`DCSM_MODE_MEM_TASK_LIST_CODE;
				cnt_r[{`DCSM_PRIMARY_STRUCT_SEL, i_sg_chan}] <=
					i_sg_task_total;
				size_r[{`DCSM_PRIMARY_STRUCT_SEL, i_sg_chan}] <=
					`DCSM_SIZE_32;
			end
			if (i_dis_set_stb) begin
				en_r[i_en_chan] <= 1'b0;
				run_r[i_en_chan] <= 1'b0;
			end
			if (i_en_set_stb) begin
				en_r[i_en_chan] <= 1'b1;
			end
			// a request on a disabled channel is simply dropped
			if (i_sw_req_stb && en_r[i_sw_req_chan]) begin
				run_r[i_sw_req_chan] <= 1'b1;
			end
		end
	end

	// strobes last one cycle and leave with the item they belong to
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_periph_done <= {NCH{1'b0}};
			o_sw_done_irq <= 1'b0;
			o_item_stb <= 1'b0;
			o_item_chan <= {CHW{1'b0}};
			o_item_size <= `DCSM_SIZE_8;
		end else begin
			o_periph_done <= {NCH{1'b0}};
			o_sw_done_irq <= 1'b0;
			o_item_stb <= any_elig;
			if (any_elig) begin
				o_item_chan <= sel_chan;
				o_item_size <= size_r[sel_s];
			end
			if (any_elig && sel_last) begin
				if (sel_chan == SW_CHAN) begin
					o_sw_done_irq <= 1'b1;
				end else begin
					o_periph_done[sel_chan] <= 1'b1;
				end
			end
		end
	end

	// selection state belongs to software alone; the engine never writes it
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_sel_r <= {NCH{`DCSM_RST_SEC_SEL}};
			ptl_flag_r <= {NCH{`DCSM_RST_PTL_FLAG}};
		end else begin
			if (i_sg_set_stb) begin
				ptl_flag_r[i_sg_chan] <= i_sg_periph_flag;
			end
			// secondary comes last so it wins a same-cycle clash
			if (i_sel_default_stb) begin
				sec_sel_r <= sec_sel_r & ~i_sel_mask;
			end
			if (i_sel_secondary_stb) begin
				sec_sel_r <= sec_sel_r | i_sel_mask;
			end
		end
	end

	// status reads are registered one cycle behind the index
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_query_enabled <= 1'b0;
			o_query_mode <= `DCSM_MODE_STOP;
			o_query_items <= {CW{1'b0}};
			o_enabled <= {NCH{1'b0}};
			o_secondary_source_sel <= {NCH{1'b0}};
			o_periph_task_list_flag <= {NCH{1'b0}};
		end else begin
			o_query_enabled <= en_r[i_query_index[CHW-1:0]];
			o_query_mode <= mode_r[i_query_index];
			o_query_items <= cnt_r[i_query_index];
			o_enabled <= en_r;
			o_secondary_source_sel <= sec_sel_r;
			o_periph_task_list_flag <= ptl_flag_r;
		end
	end

endmodule

`default_nettype wire

/* File: dv/dcsm_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dcsm_checker #(
	parameter CHW = 5,
	parameter [CHW-1:0] SW_CHAN = 30
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_en_set_stb,
	input wire i_dis_set_stb,
	input wire [CHW-1:0] i_en_chan,
	input wire [CHW:0] i_query_index,
	input wire i_sel_default_stb,
	input wire i_sel_secondary_stb,
	input wire [(1<<CHW)-1:0] i_sel_mask,
	input wire o_query_enabled,
	input wire [(1<<CHW)-1:0] o_enabled,
	input wire [(1<<CHW)-1:0] o_secondary_source_sel,
	input wire [(1<<CHW)-1:0] o_periph_done,
	input wire o_sw_done_irq,
	input wire o_item_stb,
	input wire [CHW-1:0] o_item_chan
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	chk_sw_irq_item: assert property (
		o_sw_done_irq |-> o_item_stb && o_item_chan == SW_CHAN)
		else $error("sw irq without last item");
	chk_sw_no_periph: assert property (!o_periph_done[SW_CHAN])
		else $error("periph done on sw channel");
	chk_done_last_item: assert property (
		|o_periph_done |-> o_item_stb && o_periph_done == (1 << o_item_chan))
		else $error("done pulse not on last item");
	chk_item_enabled: assert property (
		o_item_stb |-> o_enabled[o_item_chan])
		else $error("item on disabled channel");
	chk_en_set: assert property (
		i_en_set_stb |-> ##2 o_enabled[$past(i_en_chan, 2)])
		else $error("enable not set");
	chk_dis_clear: assert property (
		i_dis_set_stb && !i_en_set_stb |-> ##2
		!o_enabled[$past(i_en_chan, 2)])
		else $error("disable not taken");
	chk_sec_set: assert property (i_sel_secondary_stb |-> ##2
		(o_secondary_source_sel & $past(i_sel_mask, 2)) ==
		$past(i_sel_mask, 2))
		else $error("secondary not selected");
	chk_def_clear: assert property (
		i_sel_default_stb && !i_sel_secondary_stb |-> ##2
		(o_secondary_source_sel & $past(i_sel_mask, 2)) == '0)
		else $error("default not selected");
	chk_query_en: assert property (
		o_query_enabled == o_enabled[$past(i_query_index[CHW-1:0])])
		else $error("query enable wrong");
	cover property (o_sw_done_irq);
	cover property (|o_periph_done);
	cover property (o_item_stb ##1 o_item_stb);
endmodule
`default_nettype wire

/* File: dv/dcsm_periph.sv */
`timescale 1ns/1ps
`default_nettype none
module dcsm_periph (
	input wire i_clk,
	input wire [31:0] i_done,
	output logic [31:0] o_def_req,
	output logic [31:0] o_sec_req
);
	initial begin
		o_def_req = '0;
		o_sec_req = '0;
	end
	task automatic raise(input bit sec, input int ch);
		if (sec)
			o_sec_req[ch] = 1'b1;
		else
			o_def_req[ch] = 1'b1;
	endtask
	// request held until the channel reports completion
	always @(negedge i_clk) begin
		o_def_req = o_def_req & ~i_done;
		o_sec_req = o_sec_req & ~i_done;
	end
endmodule
`default_nettype wire

/* File: dv/tb_dcsm_channel_status_and_mapping.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcsm_defs.vh"
module tb_dcsm_channel_status_and_mapping;
	logic i_clk = 0, i_nrst = 0, i_en_set_stb = 0, i_dis_set_stb = 0;
	logic i_xfer_set_stb = 0, i_sg_set_stb = 0, i_sg_periph_flag = 0;
	logic i_sw_req_stb = 0, i_sel_default_stb = 0, i_sel_secondary_stb = 0;
	logic [4:0] i_en_chan = 0, i_sg_chan = 0, i_sw_req_chan = 0, o_item_chan;
	logic [5:0] i_query_index = 0, i_xfer_index = 0;
	logic [2:0] i_xfer_mode = 0, o_query_mode;
	logic [1:0] i_xfer_size = 0, o_item_size;
	logic [9:0] i_xfer_items = 0, i_sg_task_total = 0, o_query_items;
	logic [31:0] i_sel_mask = 0, i_default_source_req, i_secondary_source_req;
	logic [31:0] o_enabled, o_secondary_source_sel, o_periph_task_list_flag;
	logic [31:0] o_periph_done;
	logic o_query_enabled, o_sw_done_irq, o_item_stb;
	int n_fail = 0, tests_run = 0, cyc = 0, m_mode[64], m_items[64];
	int m_size[64];
	dcsm_top #(.SW_CHAN(5'd30)) dut (.*);
	dcsm_periph u_per (.i_clk(i_clk), .i_done(o_periph_done),
		.o_def_req(i_default_source_req), .o_sec_req(i_secondary_source_req));
	always #50 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, got);
		tests_run++;
		if (exp !== got) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge i_clk);
		s = 1'b1;
		@(negedge i_clk);
		s = 1'b0;
	endtask
	task automatic setx(input int idx, md, n);
		i_xfer_index = 6'(idx);
		i_xfer_mode = 3'(md);
		i_xfer_items = 10'(n);
		i_xfer_size = 2'($urandom_range(2));
		// only six codes exist; the rest must read back as stopped
		m_mode[idx] = (md == 5 || md == 7) ? 0 : md;
		m_items[idx] = n;
		m_size[idx] = i_xfer_size;
		pulse(i_xfer_set_stb);
	endtask
	task automatic q(input int idx, input bit en);
		i_query_index = 6'(idx);
		repeat (2) @(negedge i_clk);
		chk("query enabled", en, o_query_enabled);
		chk("query mode", m_mode[idx], o_query_mode);
		chk("query items", m_items[idx], o_query_items);
	endtask
	task automatic go(input int ch, n, input bit en);
		int seen, dn;
		seen = 0;
		dn = 0;
		repeat (n + 12) begin
			@(negedge i_clk);
			seen += (o_item_stb === 1'b1 && o_item_chan == ch);
			if (o_item_stb === 1'b1 && o_item_chan == ch)
				chk("item size", m_size[ch], o_item_size);
			dn += (o_periph_done[ch] === 1'b1 || (o_sw_done_irq && ch == 30));
		end
		chk("items moved", n, seen);
		chk("done pulses", n > 0, dn);
		if (n > 0) begin
			m_mode[ch] = 0;
			m_items[ch] = 0;
		end
		q(ch, en);
	endtask
	initial begin
		void'($urandom(32'h057c));
		repeat (6) @(posedge i_clk);
		@(negedge i_clk);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_clk);
		chk("enabled after reset", 0, o_enabled);
		for (int k = 0; k < 8; k++) begin
			setx(39, k, $urandom_range(1, 1000));
			q(39, 0);
		end
		q(7, 0);
		$display("test modes done");
		for (int k = 0; k < 2; k++) begin
			int ch, n;
			ch = k ? 30 : 3;
			n = $urandom_range(1, 6);
			setx(ch, `DCSM_MODE_AUTO, n);
			i_en_chan = 5'(ch);
			pulse(i_en_set_stb);
			q(ch, 1);
			i_sw_req_chan = 5'(ch);
			pulse(i_sw_req_stb);
			go(ch, n, 0);
		end
		setx(4, `DCSM_MODE_AUTO, 2);
		i_en_chan = 5'd4;
		pulse(i_en_set_stb);
		pulse(i_dis_set_stb);
		i_sw_req_chan = 5'd4;
		pulse(i_sw_req_stb);
		go(4, 0, 0);
		$display("test software requests done");
		for (int k = 0; k < 3; k++) begin
			setx(5, `DCSM_MODE_BASIC, 3);
			i_en_chan = 5'd5;
			pulse(i_en_set_stb);
			i_sel_mask = 32'h20 | $urandom;
			if (k == 1) pulse(i_sel_secondary_stb);
			u_per.raise(k == 2, 5);
			go(5, k == 1 ? 0 : 3, k == 1);
		end
		i_sel_mask = '1;
		pulse(i_sel_default_stb);
		@(negedge i_clk);
		chk("secondary select", 0, o_secondary_source_sel);
		$display("test source select done");
		for (int k = 0; k < 2; k++) begin
			i_sg_chan = 5'd8;
			i_sg_task_total = 10'(k + 5);
			i_sg_periph_flag = 1'(k);
			m_mode[8] = k ? 6 : 4;
			m_items[8] = k + 5;
			pulse(i_sg_set_stb);
			@(negedge i_clk);
			chk("task list flag", k, o_periph_task_list_flag[8]);
			q(8, 0);
		end
		$display("test task list done");
		finish_test();
	end
endmodule
bind dcsm_top dcsm_checker #(.CHW(CHW), .SW_CHAN(SW_CHAN)) u_chk (
	.i_clk(i_clk),
	.i_nrst(i_nrst),
	.i_en_set_stb(i_en_set_stb),
	.i_dis_set_stb(i_dis_set_stb),
	.i_en_chan(i_en_chan),
	.i_query_index(i_query_index),
	.i_sel_default_stb(i_sel_default_stb),
	.i_sel_secondary_stb(i_sel_secondary_stb),
	.i_sel_mask(i_sel_mask),
	.o_query_enabled(o_query_enabled),
	.o_enabled(o_enabled),
	.o_secondary_source_sel(o_secondary_source_sel),
	.o_periph_done(o_periph_done),
	.o_sw_done_irq(o_sw_done_irq),
	.o_item_stb(o_item_stb),
	.o_item_chan(o_item_chan)
);
`default_nettype wire
